// ---- hdl/tx_err_pkg.sv ----
// Constants shared by the transmit error-status block and its control end.
// Assumes one 40 MHz clock and a synchronous active-high reset for both ends.
//
// Behaviour
// - Interrupt when any enabled flag set; here bit 8 never interrupts, even when enabled.
// - Software clears serviced flags, checks none pending.
// - Bit 8 plain read/write storage, resets zero.
// - Bit 7 on unexpected lane FIFO empty.
// - Bit 6 on unexpected lane FIFO full.
// - FIFO error needs transceiver and link reset.
// - Bit 5 on lane PLL lock loss.
// - Bit 4 when SYNC_N low too long.
// - Reinit request returns link to K28.5 sync.
// - Bit 3 when transport valid drops.
// - Upstream gives valid data whenever ready asserted.
// - Bit 2 on invalid link data when requested.
// - Integrator may tie fault 0, valid 1.
// - Bit 1 on SYSREF period not LMFC multiple.
// - Bit 0 on receiver SYNC_N error report.
// - SYSREF rising edge resets multiframe counter; only with sysref_continuous set.
package tx_err_pkg;

  // ****************************************
  // Register layout
  // ****************************************
  localparam logic [7:0] FLAGS_OFFSET = 8'h60;
  localparam logic [7:0] ENABLE_OFFSET = 8'h64;
  localparam int FLAG_W = 9;
  localparam int BIT_SPARE = 8;
  localparam int BIT_FIFO_EMPTY = 7;
  localparam int BIT_FIFO_FULL = 6;
  localparam int BIT_PLL_LOCK = 5;
  localparam int BIT_REINIT = 4;
  localparam int BIT_FRAME_INVALID = 3;
  localparam int BIT_LINK_INVALID = 2;
  localparam int BIT_SYSREF_LMFC = 1;
  localparam int BIT_SYNC_ERR = 0;
  localparam logic [8:0] FLAGS_RESET = 9'h000;
  localparam logic [8:0] ENABLE_RESET = 9'h1F1;
  localparam logic [8:0] EVENT_MASK = 9'h0FF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int REINIT_FRAMES = 5;
  localparam int REINIT_OCTETS = 9;
  localparam int DEF_OCTETS_PER_FRAME = 1;
  localparam int DEF_FRAMES_PER_MF = 32;
  localparam int CNT_W = 16;

  // Link state reported on the device end's status output
  typedef enum logic [1:0] {LS_CGS, LS_ILAS, LS_DATA} link_state_e;

endpackage : tx_err_pkg

// ---- hdl/tx_err_if.sv ----
// Interface joining the error-status device end and its control end.
// Assumes both ends share clk and srst.
`timescale 1ns/1ps
interface tx_err_if (
  input wire logic clk
);
  import tx_err_pkg::*;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic irq;
  logic link_reset;

  modport device (input wr_en, input rd_en, input addr, input wdata,
    output rdata, output irq, input link_reset);
  modport control (output wr_en, output rd_en, output addr, output wdata,
    input rdata, input irq, output link_reset);
endinterface : tx_err_if

// ---- hdl/tx_link_error_status.sv ----
// Device end: sticky transmit error flags, their enables and the interrupt.
// Link counts run in clocks of four octets each.
// Assumes all event inputs are synchronous to clk; link events are levels.
`timescale 1ns/1ps
module tx_link_error_status
  import tx_err_pkg::*;
#(
  parameter int OCTETS_PER_FRAME = DEF_OCTETS_PER_FRAME,
  parameter int FRAMES_PER_MF = DEF_FRAMES_PER_MF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register side
  tx_err_if.device bus,
  // Lane status
  input wire logic link_running,
  input wire logic lane_fifo_empty,
  input wire logic lane_fifo_full,
  input wire logic lane_pll_locked,
  // Receiver sync and reference
  input wire logic sync_n,
  input wire logic sync_err_report,
  input wire logic sysref,
  input wire logic sysref_continuous,
  // Transport and link streaming
  input wire logic transport_present,
  input wire logic upstream_sample_valid,
  input wire logic upstream_sample_ready,
  input wire logic transport_frame_fault_in,
  input wire logic link_input_valid,
  input wire logic link_data_request,
  // Status
  output logic [1:0] link_state,
  output logic send_k28_5,
  output logic [CNT_W-1:0] lmfc_count
);

  // ****************************************
  // State
  // ****************************************
  // Multiframe length and restart limit, both in link clocks
  localparam int LMFC_PERIOD = (FRAMES_PER_MF * OCTETS_PER_FRAME) / 4;
  localparam logic [CNT_W-1:0] LMFC_LAST = CNT_W'(LMFC_PERIOD - 1);
  localparam logic [CNT_W-1:0] REINIT_LIMIT =
    CNT_W'((REINIT_FRAMES * OCTETS_PER_FRAME + REINIT_OCTETS) / 4);

  // Whole state of the device end in one register
  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic [CNT_W-1:0] sync_low_cnt;
    logic [CNT_W-1:0] lmfc;
    logic sysref_d;
    link_state_e lstate;
    logic [31:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // ****************************************
  // Event detection
  // ****************************************
  // One level per flag bit; bit 8 has no event and never interrupts
  logic [FLAG_W-1:0] ev;
  logic sys_rise;
  logic lmfc_wrap;
  logic reinit_hit;

  // Delayed copy resets low, the idle level of the pin, so no false edge
  assign sys_rise = sysref & ~st_r.sysref_d;

  // Multiframe counter sits on its last count this cycle
  assign lmfc_wrap = (st_r.lmfc == LMFC_LAST);

  // Line low past the limit; ignored in code group sync, where the
  // receiver holds it low on purpose until it has locked
  assign reinit_hit = (st_r.lstate != LS_CGS) && !sync_n
    && (st_r.sync_low_cnt == REINIT_LIMIT);

  // Event levels, sampled every cycle; a level that stays up keeps
  // setting its flag, so a clear only sticks once the cause is gone
  always_comb begin
    ev = '0;
    // Lane faults count only while the link runs; start-up is ignored
    ev[BIT_FIFO_EMPTY] = link_running & lane_fifo_empty;
    ev[BIT_FIFO_FULL] = link_running & lane_fifo_full;
    ev[BIT_PLL_LOCK] = link_running & ~lane_pll_locked;

    // Receiver asked for a restart
    ev[BIT_REINIT] = reinit_hit;

    // Upstream must have a sample whenever one is asked for
    ev[BIT_FRAME_INVALID] = transport_present & upstream_sample_ready
      & (~upstream_sample_valid | transport_frame_fault_in);
    ev[BIT_LINK_INVALID] = link_data_request & ~link_input_valid;

    // Reference edge off a multiframe boundary: period not a multiple
    ev[BIT_SYSREF_LMFC] = sysref_continuous & sys_rise & ~lmfc_wrap;
    // Receiver error report passes straight through
    ev[BIT_SYNC_ERR] = sync_err_report;
  end

  // ****************************************
  // Next state
  // ****************************************
  // Set wins over a same-cycle write-one clear, so no event is lost
  always_comb begin
    st_nxt = st_r;
    // Reference delay for the edge detector
    st_nxt.sysref_d = sysref;

    // Reinit detect: count clocks of SYNC_N low, saturating past the limit
    if (sync_n) begin
      st_nxt.sync_low_cnt = '0;
    end else if (st_r.sync_low_cnt <= REINIT_LIMIT) begin
      st_nxt.sync_low_cnt = st_r.sync_low_cnt + CNT_W'(1);
    end

    // Local multiframe counter; a reference edge realigns it while sysref_continuous is set
    if (sysref_continuous && sys_rise) begin
      st_nxt.lmfc = '0;
    end else if (lmfc_wrap) begin
      st_nxt.lmfc = '0;
    end else begin
      st_nxt.lmfc = st_r.lmfc + CNT_W'(1);
    end

    // Link state: sync characters until the receiver releases the line,
    // then one multiframe of alignment, then data
    case (st_r.lstate)
      LS_CGS: begin
        // Leave only on a multiframe boundary so both ends agree on it
        if (sync_n && lmfc_wrap) begin
          st_nxt.lstate = LS_ILAS;
        end
      end
      LS_ILAS: begin
        if (lmfc_wrap) begin
          st_nxt.lstate = LS_DATA;
        end
      end
      LS_DATA: begin
        // Stay put; a restart request is handled below for every state
        st_nxt.lstate = LS_DATA;
      end
      default: begin
        st_nxt.lstate = LS_CGS;
      end
    endcase
    // A restart request wins over any advance and resends sync characters
    if (ev[BIT_REINIT]) begin
      st_nxt.lstate = LS_CGS;
    end

    // Register writes: write-one-clear flags, plain spare bit; a write of
    // zero leaves a flag alone, so software clears only what it serviced
    if (bus.wr_en && bus.addr == FLAGS_OFFSET) begin
      st_nxt.flags = st_r.flags & ~(bus.wdata[FLAG_W-1:0] & EVENT_MASK);
      st_nxt.flags[BIT_SPARE] = bus.wdata[BIT_SPARE];
    end
    if (bus.wr_en && bus.addr == ENABLE_OFFSET) begin
      st_nxt.enable = bus.wdata[FLAG_W-1:0];
    end
    // Events are applied last so they win over the clear above
    st_nxt.flags = st_nxt.flags | (ev & EVENT_MASK);

    // Registered read data, valid the cycle after the strobe; the bus
    // reads zero when idle so a stray sample cannot look like a flag
    st_nxt.rdata = '0;
    if (bus.rd_en) begin
      case (bus.addr)
        FLAGS_OFFSET: st_nxt.rdata = {23'h000000, st_r.flags};
        ENABLE_OFFSET: st_nxt.rdata = {23'h000000, st_r.enable};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end

    // Link reset from the control end restarts link tracking
    // Flags are kept: software must still see what caused the reset
    if (bus.link_reset) begin
      st_nxt.lstate = LS_CGS;
      st_nxt.lmfc = '0;
      st_nxt.sync_low_cnt = '0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset clears the flags and restores the enable defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{flags: FLAGS_RESET, enable: ENABLE_RESET, sync_low_cnt: '0,
        lmfc: '0, sysref_d: 1'b0, lstate: LS_CGS, rdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Interrupt is a level from flags and enables; it drops as soon as the
  // last enabled flag is cleared or its enable is taken away
  assign bus.irq = |(st_r.flags & st_r.enable & EVENT_MASK);
  // Read data straight from its register
  assign bus.rdata = st_r.rdata;
  // Status views of the link tracker
  assign link_state = st_r.lstate;
  assign send_k28_5 = (st_r.lstate == LS_CGS);
  assign lmfc_count = st_r.lmfc;

endmodule : tx_link_error_status

// ---- hdl/tx_err_service.sv ----
// Control end: services the interrupt by reading, clearing and rechecking.
// Assumes the device end answers a read with rdata one cycle later.
`timescale 1ns/1ps
module tx_err_service
  import tx_err_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Device side
  tx_err_if.control bus,
  // User side
  input wire logic [FLAG_W-1:0] enable_value,
  input wire logic enable_load,
  output logic [FLAG_W-1:0] last_flags,
  output logic fifo_reset_req,
  output logic busy
);

  // ****************************************
  // Service sequencer
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_EN, S_ENRD, S_RD, S_WAIT, S_CLR, S_CHK} svc_e;

  typedef struct packed {
    svc_e st;
    logic [FLAG_W-1:0] flags;
    logic fifo_rst;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Read, clear what was seen, then read again until nothing pending
  always_comb begin
    st_nxt = st_r;
    st_nxt.fifo_rst = 1'b0;
    bus.wr_en = 1'b0;
    bus.rd_en = 1'b0;
    bus.addr = FLAGS_OFFSET;
    bus.wdata = 32'h00000000;
    case (st_r.st)
      S_IDLE: begin
        if (enable_load) begin
          st_nxt.st = S_EN;
        end else if (bus.irq) begin
          st_nxt.st = S_RD;
        end
      end
      S_EN: begin
        bus.wr_en = 1'b1;
        bus.addr = ENABLE_OFFSET;
        bus.wdata = {23'h000000, enable_value};
        st_nxt.st = S_ENRD;
      end
      // Read the enables back so a lost write shows on the bus
      S_ENRD: begin
        bus.rd_en = 1'b1;
        bus.addr = ENABLE_OFFSET;
        st_nxt.st = S_IDLE;
      end
      S_RD: begin
        bus.rd_en = 1'b1;
        st_nxt.st = S_WAIT;
      end
      S_WAIT: begin
        st_nxt.flags = bus.rdata[FLAG_W-1:0];
        st_nxt.st = S_CLR;
      end
      S_CLR: begin
        bus.wr_en = 1'b1;
        bus.wdata = {23'h000000, st_r.flags};
        st_nxt.fifo_rst = st_r.flags[BIT_FIFO_EMPTY] | st_r.flags[BIT_FIFO_FULL];
        st_nxt.st = S_CHK;
      end
      S_CHK: begin
        st_nxt.st = bus.irq ? S_RD : S_IDLE;
      end
      default: st_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{st: S_IDLE, flags: '0, fifo_rst: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.link_reset = st_r.fifo_rst;
  assign fifo_reset_req = st_r.fifo_rst;
  assign last_flags = st_r.flags;
  assign busy = (st_r.st != S_IDLE);

endmodule : tx_err_service

// ---- verification/tx_err_checker.sv ----
// Assertions on the error-status register bus.
// Assumes it sits beside the interface, on its clk and srst.
`timescale 1ns/1ps
module tx_err_checker
  import tx_err_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic link_reset
);
  wire logic wr_flags = wr_en && addr == FLAGS_OFFSET;
  logic [7:0] seen_r;
  logic [8:0] en_r;
  logic spare_r;
  logic rd_d_r;
  // ****
  // Shadows
  // ****
  // Seen flags only shrink by a write of one
  always_ff @(posedge clk) begin
    if (srst) begin
      seen_r <= 8'h00;
      en_r <= ENABLE_RESET;
      spare_r <= 1'b0;
      rd_d_r <= 1'b0;
    end else begin
      rd_d_r <= rd_en && addr == FLAGS_OFFSET;
      seen_r <= (rd_d_r ? rdata[7:0] : seen_r) & ~(wr_flags ? wdata[7:0] : 8'h00);
      if (wr_flags) spare_r <= wdata[8];
      if (wr_en && addr == ENABLE_OFFSET) en_r <= wdata[8:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****
  // Properties
  // ****
  // Reads without a write in the same cycle
  sequence rd_flags;
    rd_en && !wr_en && addr == FLAGS_OFFSET;
  endsequence
  sequence rd_enable;
    rd_en && !wr_en && addr == ENABLE_OFFSET;
  endsequence
  AST_UPPER_ZERO: assert property (rdata[31:9] == 23'h0)
    else $error("rdata upper bits set");
  AST_IDLE_ZERO: assert property (!rd_en |=> rdata == 32'h0)
    else $error("rdata not zero without read");
  AST_UNMAPPED: assert property (rd_en && addr != FLAGS_OFFSET && addr != ENABLE_OFFSET
    |=> rdata == 32'h0) else $error("unmapped read not zero");
  AST_STICKY: assert property (rd_flags |=> (rdata[7:0] & seen_r) == seen_r)
    else $error("flag lost without clear");
  AST_SPARE: assert property (rd_flags |=> rdata[8] == spare_r)
    else $error("spare bit mismatch");
  AST_ENABLE_RB: assert property (rd_enable |=> rdata[8:0] == en_r)
    else $error("enable readback mismatch");
  AST_IRQ_EN: assert property (rd_flags ##1 (rdata[7:0] & en_r[7:0]) != 8'h00 |-> irq)
    else $error("enabled flag without irq");
  AST_LRST_PULSE: assert property (link_reset |=> !link_reset)
    else $error("link reset not a pulse");
endmodule : tx_err_checker

// ---- verification/tb_tx_link_error_status.sv ----
// Testbench joining device and service ends through the interface.
// Assumes the service end clears every flag it reads.
`timescale 1ns/1ps
module tb_tx_link_error_status;
  import tx_err_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic link_running = 1'b1, lane_pll_locked = 1'b1, sync_n = 1'b1, link_input_valid = 1'b1;
  logic upstream_sample_valid = 1'b1, transport_present = 1'b1, lane_fifo_empty = 1'b0;
  logic lane_fifo_full = 1'b0, sync_err_report = 1'b0, sysref = 1'b0, enable_load = 1'b0;
  logic sysref_continuous = 1'b0, upstream_sample_ready = 1'b0, link_data_request = 1'b0;
  logic transport_frame_fault_in = 1'b0;
  logic [8:0] enable_value = 9'h000;
  logic [8:0] last_flags;
  logic fifo_reset_req, busy, send_k28_5, fr;
  logic [1:0] link_state;
  logic [CNT_W-1:0] lmfc_count;
  int errors = 0;
  int compares = 0;
  // Ordinary cases: event code beside the flags it must leave
  int row_ev [7] = '{0, 1, 3, 5, 6, 7, 8};
  logic [8:0] row_exp [7] = '{9'h001, 9'h002, 9'h008, 9'h020, 9'h040, 9'h080, 9'h008};
  tx_err_if bus (.clk);
  tx_link_error_status tx_link_error_status_inst (.clk, .srst, .bus, .link_running,
    .lane_fifo_empty, .lane_fifo_full, .lane_pll_locked, .sync_n, .sync_err_report, .sysref,
    .sysref_continuous, .transport_present, .upstream_sample_valid, .upstream_sample_ready,
    .transport_frame_fault_in, .link_input_valid, .link_data_request, .link_state,
    .send_k28_5, .lmfc_count);
  tx_err_service tx_err_service_inst (.clk, .srst, .bus, .enable_value, .enable_load,
    .last_flags, .fifo_reset_req, .busy);
  tx_err_checker tx_err_checker_inst (.clk, .srst, .wr_en(bus.wr_en), .rd_en(bus.rd_en),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .irq(bus.irq),
    .link_reset(bus.link_reset));
  // ****
  // Clock and helpers
  // ****
  initial forever #12.5 clk = ~clk;
  // Latch any FIFO reset pulse, too short to poll
  always @(posedge clk) if (fifo_reset_req === 1'b1) fr <= 1'b1;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  // Event levels by code; 2 is the default
  task drive(input int ev, input logic on);
    case (ev)
      0: sync_err_report <= on;
      1: begin
        sysref_continuous <= 1'b1;
        sysref <= on;
      end
      3: upstream_sample_valid <= !on;
      4: sync_n <= !on;
      5: lane_pll_locked <= !on;
      6: lane_fifo_full <= on;
      7: lane_fifo_empty <= on;
      8: transport_frame_fault_in <= on;
      9: sysref <= on;
      default: link_data_request <= on;
    endcase
    if (ev == 3 || ev == 8) upstream_sample_ready <= on;
    if (ev == 2) link_input_valid <= !on;
  endtask : drive
  task pulse(input int ev, input int hold);
    @(posedge clk);
    drive(ev, 1'b1);
    repeat (hold) @(posedge clk);
    drive(ev, 1'b0);
  endtask : pulse
  task load(input logic [8:0] v);
    @(posedge clk);
    enable_value <= v;
    enable_load <= 1'b1;
    @(posedge clk);
    enable_load <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : load
  // Bounded wait until serviced; a timeout ends the run
  task settle(input logic [8:0] exp);
    int n;
    n = 0;
    while ((bus.irq !== 1'b0 || busy !== 1'b0 || n < 8) && n < 400) begin
      tick;
      n++;
    end
    if (n >= 400) begin
      errors++;
      wrap_up();
    end else begin
      chk(last_flags, exp);
    end
  endtask : settle
  // ****
  // Sequence
  // ****
  initial begin
    int n;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tick;
    chk(bus.irq, 0);
    chk(link_state, LS_CGS);
    pulse(9, 1);
    load(9'h1FB);
    for (int i = 0; i < 7; i++) begin
      fr = 1'b0;
      repeat (2) pulse(row_ev[i], 1);
      settle(row_exp[i]);
      chk(fr, |row_exp[i][7:6]);
    end
    // Reinit needs the link out of code group sync first
    n = 0;
    while (link_state === LS_CGS && n < 400) begin
      tick;
      n++;
    end
    chk(n < 400, 1);
    if (n >= 400) wrap_up();
    pulse(4, 8);
    #1;
    chk(send_k28_5, 1);
    settle(9'h010);
    // Reference edge at a known count: counter zeroed, period error flagged
    n = 0;
    while (lmfc_count !== 16'h0003 && n < 400) begin
      tick;
      n++;
    end
    chk(n < 400, 1);
    if (n >= 400) wrap_up();
    @(posedge clk);
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    #1;
    chk(lmfc_count, 0);
    settle(9'h002);
    // Disabled flag stays quiet until enabled
    pulse(2, 1);
    repeat (10) tick;
    chk(bus.irq, 0);
    load(9'h1FF);
    settle(9'h004);
    // Reset mid-run: flags, state and enables back to their defaults
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    tick;
    chk(bus.irq, 0);
    chk(link_state, LS_CGS);
    chk(last_flags, 0);
    pulse(2, 1);
    repeat (10) tick;
    chk(bus.irq, 0);
    wrap_up();
  end
endmodule : tb_tx_link_error_status
